// ---- lnbtc_pkg.sv ----
package lnbtc_pkg;

	// ----------------------------------------------------------------
	// clocking and tone timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ         = 25_000_000;
	localparam int TONE_HZ        = 22_000;
	localparam int BOOST_MULT     = 16;
	localparam int BOOST_DIV      = CLK_HZ / (TONE_HZ * BOOST_MULT);
	localparam int BOOST_HALF     = BOOST_DIV / 2;
	localparam int DIV_W          = 7;
	localparam logic [DIV_W-1:0] BOOST_DIV_M1 = DIV_W'(BOOST_DIV - 1);
	localparam logic [DIV_W-1:0] BOOST_HALF_C = DIV_W'(BOOST_HALF);
	localparam int TONE_PH_W      = 4;

	// tone detector hold: one tone cycle of boost ticks
	localparam int DET_HOLD_W     = 5;
	localparam logic [DET_HOLD_W-1:0] DET_HOLD_TICKS = 5'h10;
	// tone-present hold: two tone cycles of boost ticks
	localparam int GEN_HOLD_W     = 6;
	localparam logic [GEN_HOLD_W-1:0] GEN_HOLD_TICKS = 6'h20;

	// ----------------------------------------------------------------
	// overcurrent timing
	// ----------------------------------------------------------------
	localparam int OC_TIME_MS     = 48;
	localparam int OC_TRIP_CYC    = (CLK_HZ / 1000) * OC_TIME_MS;
	localparam int OC_CNT_W       = 21;
	localparam int RESTART_GAP_S  = 2;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int NUM_CH         = 2;
	localparam int REG_STRIDE     = 4;
	localparam logic [7:0] OFS_CTRL0  = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK   = 8'h0C;

	// control register fields
	localparam int BIT_SRC        = 0;
	localparam int BIT_GATE       = 1;
	localparam int BIT_EN         = 2;

	// status / mask register fields
	localparam int POS_OC         = 0;
	localparam int POS_TONE       = 2;
	localparam int POS_DIS        = 4;

	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [1:0] RST_MASK = 2'h0;

endpackage

// ---- lnbtc_top.sv ----
// Function
// - An uninterrupted overcurrent lasting longer than 48 ms disables the channel and sets its fault flag.
// - After an overcurrent shutdown the channel stays off until the host enables it again.
// - The boost converter clock runs at sixteen times the internal tone rate, about 352 kHz.
// - The source select bit picks the internal 22 kHz oscillator at 1 and the modulation pin at 0.
// - With internal source and pin held high, the gate bit alone switches the internal tone.
// - With internal source and gate set, the modulation pin level switches the internal tone.
// - With external source, a continuous clock on the pin is passed only while the gate bit is set.
// - With external source and gate set, a stopped pin parks the output at its held level.
// - A tone leaves only when both gate bit and pin allow it, so either at 0 stops transmission.
// - The tone-present flag is set whenever a tone is being generated, in every option.
// - The detector pulls its open-drain output low while a tone is received, lagging at most one tone cycle.
// - The overcurrent fault flag is latched, requests an interrupt, and holds until cleared.
// - The tone-present flag follows the channel live and never raises the interrupt.
// - All control bits, tone source and gate included, are 0 after power-up.
//
// Local design decisions: the plain strobed port and the placing of the registers.
module lnbtc_top
	import lnbtc_pkg::*;
#(
	parameter int OC_TRIP_CYCLES = OC_TRIP_CYC
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	// register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	// channel pins in
	input  wire logic [NUM_CH-1:0] oc_det,
	input  wire logic [NUM_CH-1:0] external_modulation_pin,
	input  wire logic [NUM_CH-1:0] tone_rx_in,
	// channel outputs
	output logic      [NUM_CH-1:0] lnb_out_en,
	output logic      [NUM_CH-1:0] boost_clk,
	output logic      [NUM_CH-1:0] tone_mod_en,
	output logic      [NUM_CH-1:0] tone_mod_level,
	// open-drain tone detect
	output logic      [NUM_CH-1:0] tone_det_o,
	output logic      [NUM_CH-1:0] tone_det_oe,
	// interrupt
	output logic                   irq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] ctrl_ofs(input int ch);
		ctrl_ofs = 8'(int'(OFS_CTRL0) + ch * REG_STRIDE);
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	localparam logic [OC_CNT_W-1:0] OC_LIMIT = OC_CNT_W'(OC_TRIP_CYCLES);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [DIV_W-1:0]      div_cnt_ff;
	logic                  boost_tick_ff;
	logic                  boost_phase_ff;
	logic [NUM_CH-1:0]     boost_clk_ff;
	logic [TONE_PH_W-1:0]  tone_ph_ff;

	logic [NUM_CH-1:0]     oc_meta_ff;
	logic [NUM_CH-1:0]     oc_sync_ff;
	logic [NUM_CH-1:0]     ext_meta_ff;
	logic [NUM_CH-1:0]     ext_sync_ff;
	logic [NUM_CH-1:0]     rx_meta_ff;
	logic [NUM_CH-1:0]     rx_sync_ff;
	logic [NUM_CH-1:0]     rx_prev_ff;

	logic [NUM_CH-1:0]     tone_source_select_ff;
	logic [NUM_CH-1:0]     tone_gate_bit_ff;
	logic [NUM_CH-1:0]     ch_en_ff;
	logic [NUM_CH-1:0]     mask_ff;

	logic [OC_CNT_W-1:0]   overcurrent_disable_timer_ff [NUM_CH];
	logic [NUM_CH-1:0]     oc_trip;
	logic [NUM_CH-1:0]     overcurrent_fault_flag_ff;
	logic [NUM_CH-1:0]     oc_clear;

	logic [NUM_CH-1:0]     mod_en_ff;
	logic [NUM_CH-1:0]     mod_lvl_ff;
	logic [NUM_CH-1:0]     mod_lvl_prev_ff;
	logic [GEN_HOLD_W-1:0] gen_hold_ff [NUM_CH];
	logic [NUM_CH-1:0]     tone_present_flag_ff;

	logic [DET_HOLD_W-1:0] det_hold_ff [NUM_CH];
	logic [NUM_CH-1:0]     det_oe_ff;
	logic [NUM_CH-1:0]     det_o_ff;

	logic [7:0]            reg_rdata_ff;
	logic [7:0]            nxt_rdata;
	logic                  irq_ff;

	// ----------------------------------------------------------------
	// boost clock divider and internal tone
	// ----------------------------------------------------------------
	// one divider feeds both, so tone and boost stay locked at 16:1
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_ff    <= '0;
			boost_tick_ff <= 1'b0;
		end else begin
			boost_tick_ff <= (div_cnt_ff == BOOST_DIV_M1);
			if (div_cnt_ff == BOOST_DIV_M1) begin
				div_cnt_ff <= '0;
			end else begin
				div_cnt_ff <= div_cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			boost_phase_ff <= 1'b0;
			boost_clk_ff   <= '0;
		end else begin
			boost_phase_ff <= (div_cnt_ff < BOOST_HALF_C);
			boost_clk_ff   <= {NUM_CH{boost_phase_ff}} & ch_en_ff;
		end
	end

	// sixteen boost ticks make one tone period
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tone_ph_ff <= '0;
		end else if (boost_tick_ff) begin
			tone_ph_ff <= tone_ph_ff + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			oc_meta_ff  <= '0;
			oc_sync_ff  <= '0;
			ext_meta_ff <= '0;
			ext_sync_ff <= '0;
			rx_meta_ff  <= '0;
			rx_sync_ff  <= '0;
			rx_prev_ff  <= '0;
		end else begin
			oc_meta_ff  <= oc_det;
			oc_sync_ff  <= oc_meta_ff;
			ext_meta_ff <= external_modulation_pin;
			ext_sync_ff <= ext_meta_ff;
			rx_meta_ff  <= tone_rx_in;
			rx_sync_ff  <= rx_meta_ff;
			rx_prev_ff  <= rx_sync_ff;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tone_source_select_ff <= '0;
			tone_gate_bit_ff      <= '0;
			ch_en_ff              <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (reg_wr && hit(reg_addr, ctrl_ofs(c))) begin
					tone_source_select_ff[c] <= reg_wdata[BIT_SRC];
					tone_gate_bit_ff[c]      <= reg_wdata[BIT_GATE];
					ch_en_ff[c]              <= reg_wdata[BIT_EN];
				end
				// a trip beats a host enable in the same cycle
				if (oc_trip[c]) begin
					ch_en_ff[c] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mask_ff <= RST_MASK;
		end else if (reg_wr && hit(reg_addr, OFS_MASK)) begin
			mask_ff <= reg_wdata[POS_OC +: NUM_CH];
		end
	end

	// ----------------------------------------------------------------
	// overcurrent timer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < NUM_CH; c++) begin
				overcurrent_disable_timer_ff[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (!oc_sync_ff[c] || !ch_en_ff[c]) begin
					overcurrent_disable_timer_ff[c] <= '0;
				end else if (overcurrent_disable_timer_ff[c] != OC_LIMIT) begin
					overcurrent_disable_timer_ff[c] <= overcurrent_disable_timer_ff[c] + 1'b1;
				end
			end
		end
	end

	// trips in the same cycle that the timer holds the full limit
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			oc_trip[c] = oc_sync_ff[c] && ch_en_ff[c] &&
				(overcurrent_disable_timer_ff[c] == OC_LIMIT);
		end
	end

	assign oc_clear = (reg_wr && hit(reg_addr, OFS_STATUS)) ?
		reg_wdata[POS_OC +: NUM_CH] : '0;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			overcurrent_fault_flag_ff <= '0;
		end else begin
			// set wins over a simultaneous clear
			overcurrent_fault_flag_ff <= oc_trip |
				(overcurrent_fault_flag_ff & ~oc_clear);
		end
	end

	// ----------------------------------------------------------------
	// tone generation
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mod_en_ff  <= '0;
			mod_lvl_ff <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (tone_source_select_ff[c]) begin
					// internal tone, gated by both bit and pin
					mod_en_ff[c]  <= ch_en_ff[c] && tone_gate_bit_ff[c] &&
						ext_sync_ff[c];
					mod_lvl_ff[c] <= tone_ph_ff[TONE_PH_W-1];
				end else begin
					// pin level passed through; a stopped pin parks there
					mod_en_ff[c]  <= ch_en_ff[c] && tone_gate_bit_ff[c];
					mod_lvl_ff[c] <= ext_sync_ff[c];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// tone-present flag
	// ----------------------------------------------------------------
	// a parked output is not a tone: only toggling reloads the hold
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mod_lvl_prev_ff      <= '0;
			tone_present_flag_ff <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				gen_hold_ff[c] <= '0;
			end
		end else begin
			mod_lvl_prev_ff <= mod_lvl_ff;
			for (int c = 0; c < NUM_CH; c++) begin
				if (mod_en_ff[c] && (mod_lvl_ff[c] != mod_lvl_prev_ff[c])) begin
					gen_hold_ff[c] <= GEN_HOLD_TICKS;
				end else if (!mod_en_ff[c]) begin
					gen_hold_ff[c] <= '0;
				end else if (boost_tick_ff && gen_hold_ff[c] != '0) begin
					gen_hold_ff[c] <= gen_hold_ff[c] - 1'b1;
				end
				tone_present_flag_ff[c] <= (gen_hold_ff[c] != '0);
			end
		end
	end

	// ----------------------------------------------------------------
	// tone detector
	// ----------------------------------------------------------------
	// hold of one tone cycle bounds both lag and stretch
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			det_oe_ff <= '0;
			det_o_ff  <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				det_hold_ff[c] <= '0;
			end
		end else begin
			det_o_ff <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				if (rx_sync_ff[c] != rx_prev_ff[c]) begin
					det_hold_ff[c] <= DET_HOLD_TICKS;
					det_oe_ff[c]   <= 1'b1;
				end else begin
					if (boost_tick_ff && det_hold_ff[c] != '0) begin
						det_hold_ff[c] <= det_hold_ff[c] - 1'b1;
					end
					det_oe_ff[c] <= (det_hold_ff[c] != '0);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_comb begin
		nxt_rdata = 8'h00;
		if (hit(reg_addr, OFS_STATUS)) begin
			nxt_rdata[POS_OC +: NUM_CH]   = overcurrent_fault_flag_ff;
			nxt_rdata[POS_TONE +: NUM_CH] = tone_present_flag_ff;
			nxt_rdata[POS_DIS +: NUM_CH]  = ~ch_en_ff;
		end else if (hit(reg_addr, OFS_MASK)) begin
			nxt_rdata[POS_OC +: NUM_CH] = mask_ff;
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (hit(reg_addr, ctrl_ofs(c))) begin
				nxt_rdata[BIT_SRC]  = tone_source_select_ff[c];
				nxt_rdata[BIT_GATE] = tone_gate_bit_ff[c];
				nxt_rdata[BIT_EN]   = ch_en_ff[c];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_ff <= nxt_rdata;
		end else begin
			reg_rdata_ff <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	// tone-present is kept out of the interrupt on purpose
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(overcurrent_fault_flag_ff & mask_ff);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata      = reg_rdata_ff;
	assign lnb_out_en     = ch_en_ff;
	assign boost_clk      = boost_clk_ff;
	assign tone_mod_en    = mod_en_ff;
	assign tone_mod_level = mod_lvl_ff;
	assign tone_det_o     = det_o_ff;
	assign tone_det_oe    = det_oe_ff;
	assign irq            = irq_ff;

endmodule

// ---- lnbtc_chk_sva.sv ----
module lnbtc_chk
	import lnbtc_pkg::*;
#(
	parameter int OC_TRIP_CYCLES = OC_TRIP_CYC
) (
	// clock and reset
	input wire logic		ref_clk,
	input wire logic		resetn,
	// register port
	input wire logic		reg_wr,
	// channel signals
	input wire logic [NUM_CH-1:0]	oc_det,
	input wire logic [NUM_CH-1:0]	tone_rx_in,
	input wire logic [NUM_CH-1:0]	lnb_out_en,
	input wire logic [NUM_CH-1:0]	boost_clk,
	input wire logic [NUM_CH-1:0]	tone_mod_en,
	input wire logic [NUM_CH-1:0]	tone_det_o,
	input wire logic [NUM_CH-1:0]	tone_det_oe,
	// interrupt
	input wire logic		irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// --------
	// overcurrent run on channel 0
	// --------
	// counts raw pin samples, so sync delay shows as slack
	logic [31:0]	oc_run_ff;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			oc_run_ff <= 32'h0;
		end else if (oc_det[0] && lnb_out_en[0]) begin
			oc_run_ff <= oc_run_ff + 32'h1;
		end else begin
			oc_run_ff <= 32'h0;
		end
	end

	// --------
	// properties
	// --------
	oc_early_a:
		assert property ($fell(lnb_out_en[0]) && !$past(reg_wr) && !$past(reg_wr, 2)
			|-> oc_run_ff >= OC_TRIP_CYCLES)
		else $error("channel 0 shut down before a full overcurrent run");
	oc_late_a:
		assert property (oc_run_ff <= OC_TRIP_CYCLES + 8)
		else $error("channel 0 kept running through a long overcurrent");
	en_hold_a:
		assert property (|(lnb_out_en & ~$past(lnb_out_en)) |-> $past(reg_wr))
		else $error("channel output came on without a host write");
	irq_src_a:
		assert property ($rose(irq) |-> $past(reg_wr) || $past(reg_wr, 2)
			|| $past(reg_wr, 3) || |($past(lnb_out_en, 3) & ~$past(lnb_out_en)))
		else $error("interrupt rose with no shutdown behind it");
	mod_off_a:
		assert property ((tone_mod_en & ~lnb_out_en & ~$past(lnb_out_en)) == 2'h0)
		else $error("modulation on a disabled channel");
	boost_off_a:
		assert property ((boost_clk & ~lnb_out_en & ~$past(lnb_out_en)) == 2'h0)
		else $error("boost clock runs on a disabled channel");
	det_od_a:
		assert property (tone_det_o == 2'h0)
		else $error("detect output drives high");
	det_resp_a:
		assert property ($rose(tone_rx_in[0]) |-> ##[1:4] tone_det_oe[0])
		else $error("detector slow to follow the received tone");

	cover property ($fell(lnb_out_en[0]));
	cover property ($rose(irq));
	cover property ($rose(tone_det_oe[0]));
endmodule

bind lnbtc_top lnbtc_chk #(.OC_TRIP_CYCLES(OC_TRIP_CYCLES)) u_chk (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.reg_wr(reg_wr),
	.oc_det(oc_det),
	.tone_rx_in(tone_rx_in),
	.lnb_out_en(lnb_out_en),
	.boost_clk(boost_clk),
	.tone_mod_en(tone_mod_en),
	.tone_det_o(tone_det_o),
	.tone_det_oe(tone_det_oe),
	.irq(irq)
);

// ---- lnbtc_lnb.sv ----
module lnbtc_lnb
	import lnbtc_pkg::*;
(
	// bench control
	input wire logic [NUM_CH-1:0]	short_req,
	// supply and modulation from the regulator
	input wire logic [NUM_CH-1:0]	lnb_out_en,
	input wire logic [NUM_CH-1:0]	tone_mod_en,
	input wire logic [NUM_CH-1:0]	tone_mod_level,
	// sensed back
	output logic [NUM_CH-1:0]	oc_det,
	output logic [NUM_CH-1:0]	tone_rx_in
);
	// a short only draws current while the supply is on
	assign oc_det = short_req & lnb_out_en;
	// comparator sees the cable low while modulation is off, else follows the level, so a parked-high line reads high
	assign tone_rx_in = tone_mod_en & tone_mod_level;
endmodule

// ---- lnbtc_tb.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import lnbtc_pkg::*;

	logic			ref_clk;
	logic			resetn;
	logic [7:0]		reg_addr;
	logic [7:0]		reg_wdata;
	logic			reg_wr;
	logic			reg_rd;
	logic [7:0]		reg_rdata;
	logic [NUM_CH-1:0]	oc_det;
	logic [NUM_CH-1:0]	ext_mod;
	logic [NUM_CH-1:0]	tone_rx_in;
	logic [NUM_CH-1:0]	lnb_out_en;
	logic [NUM_CH-1:0]	boost_clk;
	logic [NUM_CH-1:0]	tone_mod_en;
	logic [NUM_CH-1:0]	tone_mod_level;
	logic [NUM_CH-1:0]	tone_det_o;
	logic [NUM_CH-1:0]	tone_det_oe;
	logic			irq;
	logic [NUM_CH-1:0]	short_req;
	logic			pin_lvl;
	logic			use_ext;
	logic			ext_tone;
	logic			prev;
	int			err_count;
	int			checks_done;
	int			i;
	int			k;

	lnbtc_top #(.OC_TRIP_CYCLES(50)) dut (.ref_clk(ref_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .oc_det(oc_det), .external_modulation_pin(ext_mod),
		.tone_rx_in(tone_rx_in), .lnb_out_en(lnb_out_en), .boost_clk(boost_clk),
		.tone_mod_en(tone_mod_en), .tone_mod_level(tone_mod_level),
		.tone_det_o(tone_det_o), .tone_det_oe(tone_det_oe), .irq(irq));
	lnbtc_lnb lnb (.short_req(short_req), .lnb_out_en(lnb_out_en),
		.tone_mod_en(tone_mod_en), .tone_mod_level(tone_mod_level),
		.oc_det(oc_det), .tone_rx_in(tone_rx_in));

	// held level, or a free 22 kHz clock for the external options
	assign ext_mod = use_ext ? {NUM_CH{ext_tone}} : {NUM_CH{pin_lvl}};

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		ext_tone = 1'b0;
		forever begin
			repeat (BOOST_DIV * 8) @(posedge ref_clk);
			ext_tone <= ~ext_tone;
		end
	end

	// --------
	// access tasks
	// --------
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, reg_rdata, exp);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// --------
	// sequence
	// --------
	initial begin
		err_count = 0;
		checks_done = 0;
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		short_req = 2'h0;
		pin_lvl = 1'b0;
		use_ext = 1'b0;
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(OFS_CTRL0, 8'h00, "ctrl0");
		rd(OFS_CTRL0 + 8'h04, 8'h00, "ctrl1");
		rd(OFS_STATUS, 8'h30, "status");
		rd(OFS_MASK, 8'h00, "mask");
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00, "unmapped");
		// every source, gate and pin combination on channel 0
		for (i = 0; i < 8; i++) begin
			pin_lvl <= i[2];
			wr(OFS_CTRL0, {6'h01, i[1:0]});
			cyc(8);
			chk("mod_en", {7'h0, tone_mod_en[0]}, {7'h0, i[0] ? i[1] & i[2] : i[1]});
			if (!i[0]) chk("park", {7'h0, tone_mod_level[0]}, {7'h0, i[2]});
		end
		rd(OFS_CTRL0, 8'h07, "ctrl rb");
		// all masks open, so a tone leaking into the interrupt would show
		wr(OFS_MASK, 8'h0F);
		cyc(3000);
		rd(OFS_STATUS, 8'h24, "tone on");
		chk("det on", {6'h0, tone_det_oe}, 8'h01);
		chk("irq idle", {7'h0, irq}, 8'h00);
		cyc(1);
		prev = boost_clk[0];
		k = 0;
		repeat (BOOST_DIV * 32) begin
			cyc(1);
			k += (boost_clk[0] && !prev) ? 1 : 0;
			prev = boost_clk[0];
		end
		chk("boost", 8'(k), 8'h20);
		wr(OFS_CTRL0, 8'h05);
		cyc(3000);
		rd(OFS_STATUS, 8'h20, "tone off");
		chk("det off", {6'h0, tone_det_oe}, 8'h00);
		use_ext <= 1'b1;
		wr(OFS_CTRL0, 8'h06);
		cyc(3000);
		rd(OFS_STATUS, 8'h24, "ext tone");
		use_ext <= 1'b0;
		cyc(3000);
		rd(OFS_STATUS, 8'h20, "parked");
		// overcurrent with a one-cycle dip that must restart the timer
		wr(OFS_MASK, 8'h01);
		wr(OFS_CTRL0 + 8'h04, 8'h04);
		short_req <= 2'h1;
		cyc(40);
		short_req <= 2'h0;
		@(posedge ref_clk);
		short_req <= 2'h1;
		cyc(40);
		chk("no trip", {6'h0, lnb_out_en}, 8'h03);
		short_req <= 2'h3;
		for (k = 0; k < 300 && lnb_out_en !== 2'h0; k++) cyc(1);
		short_req <= 2'h0;
		if (k < 300) begin
			cyc(4);
			chk("irq", {7'h0, irq}, 8'h01);
			rd(OFS_STATUS, 8'h33, "fault");
			cyc(100);
			chk("stay off", {6'h0, lnb_out_en}, 8'h00);
			wr(OFS_STATUS, 8'h01);
			cyc(3);
			chk("irq clr", {7'h0, irq}, 8'h00);
			rd(OFS_STATUS, 8'h32, "w1c");
			// retry gap scaled far below the host's 2 s spacing to keep the run short
			wr(OFS_CTRL0, 8'h04);
			cyc(2);
			chk("restart", {6'h0, lnb_out_en}, 8'h01);
		end else begin
			err_count++;
		end
		end_of_test();
	end
endmodule
